// >>> shared/dsr_pkg.sv
// Shared constants for the serial range loader of the DAC.
package dsr_pkg;

    // Width of the serial shift chain; a daisy chain passes through all of it.
    localparam int unsigned CHAIN_BITS  = 32;
    // Width of the data field carried at the end of every frame.
    localparam int unsigned WORD_BITS   = 16;
    // Highest and lowest bit position of the command field in the chain.
    localparam int unsigned CMD_HI      = 23;
    localparam int unsigned CMD_LO      = 20;

    // Command codes.
    localparam logic [3:0] CMD_LOAD_IN   = 4'h0;
    localparam logic [3:0] CMD_COPY_DAC  = 4'h1;
    localparam logic [3:0] CMD_LOAD_BOTH = 4'h2;
    localparam logic [3:0] CMD_RNG_FIRST = 4'h8;
    localparam logic [3:0] CMD_RNG_LAST  = 4'hd;
    localparam logic [3:0] CMD_NOP       = 4'hf;

    // Range codes, equal to the low three command bits of the range command.
    localparam logic [2:0] RNG_U5        = 3'h0;
    localparam logic [2:0] RNG_U10       = 3'h1;
    localparam logic [2:0] RNG_B5        = 3'h2;
    localparam logic [2:0] RNG_B10       = 3'h3;
    localparam logic [2:0] RNG_B2P5      = 3'h4;
    localparam logic [2:0] RNG_OFS       = 3'h5;

    // Values after reset.
    localparam logic [2:0]            RNG_RESET   = RNG_U5;
    localparam logic [WORD_BITS-1:0]  WORD_RESET  = 16'h0000;
    localparam logic [CHAIN_BITS-1:0] CHAIN_RESET = 32'h0000_0000;

endpackage

// >>> testbench/dsr_host_model.sv
// Host model that frames commands onto the serial link of the loader.
`timescale 1ns/10ps
module dsr_host_model (
    output logic serial_clk,
    output logic select_load_strobe_n,
    output logic serial_in
);
    // The link clock stands still and the strobe idles high between frames.
    initial begin
        serial_clk           = 1'b0;
        select_load_strobe_n = 1'b1;
        serial_in            = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // MSB-first framing
    // Frame of n bits, 32 for a chain
    // Shifts the low n bits out MSB first with a 6 ns link clock.
    // A 32-bit frame leads with eight spare bits, as a chain needs.
    task automatic send(input logic [31:0] frame, input int n);
        select_load_strobe_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = frame[i];
            #3 serial_clk = 1'b1;
            #3 serial_clk = 1'b0;
        end
        // The data line is no longer qualified, so show a changed level.
        serial_in = ~frame[0];
        #3 select_load_strobe_n = 1'b1;
    endtask
endmodule

// >>> testbench/dsr_loader_bench.sv
// Self-checking bench for the serial range loader, full, 14-bit and 12-bit builds.
`timescale 1ns/10ps
module dsr_loader_bench;
    import dsr_pkg::*;
    logic        clk_sys, arst_n, clear_all_n, serial_clk, strobe_n, serial_in;
    logic        serial_out, load_done, load_done_12;
    logic [15:0] input_buffer, dac_buffer, exp_in, exp_dac;
    logic [11:0] ib_12, db_12;
    logic [13:0] ib_14, db_14;  // Buffers of the 14-bit build.
    logic [2:0]  range_sel, rng_12, exp_rng;
    logic [34:0] notes[$];  // Expected input, DAC code and range per load.
    int          mismatches, comparisons, seed;

    // The 8 ns system clock.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    dsr_loader #(.RES_BITS(16)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .serial_clk(serial_clk), .select_load_strobe_n(strobe_n),
        .serial_in(serial_in), .clear_all_n(clear_all_n),
        .serial_out(serial_out), .input_buffer(input_buffer),
        .dac_buffer(dac_buffer), .range_sel(range_sel), .load_done(load_done));
    // A 12-bit build on the same link shows the dropped low bits.
    dsr_loader #(.RES_BITS(12)) i_dut_12 (.clk_sys(clk_sys), .arst_n(arst_n),
        .serial_clk(serial_clk), .select_load_strobe_n(strobe_n),
        .serial_in(serial_in), .clear_all_n(clear_all_n), .serial_out(),
        .input_buffer(ib_12), .dac_buffer(db_12), .range_sel(rng_12),
        .load_done(load_done_12));
    // A 14-bit build shows the two dropped low bits.
    dsr_loader #(.RES_BITS(14)) i_dut_14 (.clk_sys(clk_sys), .arst_n(arst_n),
        .serial_clk(serial_clk), .select_load_strobe_n(strobe_n),
        .serial_in(serial_in), .clear_all_n(clear_all_n), .serial_out(),
        .input_buffer(ib_14), .dac_buffer(db_14), .range_sel(),
        .load_done());
    dsr_host_model i_host (.serial_clk(serial_clk),
        .select_load_strobe_n(strobe_n), .serial_in(serial_in));

    ////////////////////////////////////////////////////////////////////////
    // Compares one value and counts it.
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Waits, bounded, until every noted load has been seen.
    task automatic wait_idle();
        int k;
        for (k = 0; k < 20 && notes.size() != 0; k++) @(posedge clk_sys);
        if (notes.size() != 0) begin
            mismatches++;
            close_out();
        end
        repeat (2) @(posedge clk_sys);
    endtask

    // Builds a frame, notes the expected state and sends it.
    task automatic frame(input logic [3:0] cmd, input logic [15:0] d,
                         input int n);
        logic [31:0] f;
        f = $random(seed);
        f[23:0] = {cmd, f[19:16], d};
        case (cmd)
            CMD_LOAD_IN: exp_in = d;
            CMD_COPY_DAC: exp_dac = exp_in;
            CMD_LOAD_BOTH: begin
                exp_in  = d;
                exp_dac = d;
            end
            default: if (cmd >= CMD_RNG_FIRST && cmd <= CMD_RNG_LAST) begin
                exp_in  = d;
                exp_dac = d;
                exp_rng = cmd[2:0];
            end
        endcase
        notes.push_back({exp_in, exp_dac, exp_rng});
        i_host.send(f, n);
        wait_idle();
        if (n == 32) check({15'h0, serial_out}, {15'h0, f[31]});
    endtask

    // Each load pulse is compared against the oldest note.
    always @(posedge clk_sys) begin
        if (load_done === 1'b1) begin
            if (notes.size() == 0) begin
                check(16'h1, 16'h0);
            end else begin
                check(input_buffer, notes[0][34:19]);
                check(dac_buffer, notes[0][18:3]);
                check({13'h0, range_sel}, {13'h0, notes[0][2:0]});
                check({4'h0, ib_12}, {4'h0, notes[0][34:23]});
                check({4'h0, db_12}, {4'h0, notes[0][18:7]});
                check({15'h0, load_done_12}, 16'h1);
                check({2'h0, ib_14}, {2'h0, notes[0][34:21]});
                check({2'h0, db_14}, {2'h0, notes[0][18:5]});
                void'(notes.pop_front());
            end
        end
    end

    // A hang anywhere ends the run as a failure.
    initial begin
        #200000;
        mismatches++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        seed        = 32'h11d85bf0;
        mismatches  = 0;
        comparisons = 0;
        arst_n      = 1'b0;
        clear_all_n = 1'b1;
        exp_in      = WORD_RESET;
        exp_dac     = WORD_RESET;
        exp_rng     = RNG_RESET;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check(input_buffer, WORD_RESET);
        check(dac_buffer, WORD_RESET);
        check({13'h0, range_sel}, {13'h0, RNG_U5});
        $display("test reset done");
        frame(4'h9, 16'h0000, 24);
        check({13'h0, range_sel}, {13'h0, RNG_U10});
        check(dac_buffer, 16'h0000);
        frame(4'ha, 16'h8000, 24);
        check({13'h0, range_sel}, {13'h0, RNG_B5});
        check(dac_buffer, 16'h8000);
        frame(CMD_LOAD_BOTH, 16'($random(seed)), 32);
        check({13'h0, range_sel}, {13'h0, RNG_B5});
        $display("test range examples done");
        // Every code twice, alternating frame lengths, random data.
        for (int i = 0; i < 32; i++) begin
            frame(4'(i), 16'($random(seed)), (i % 2) ? 32 : 24);
        end
        $display("test all commands done");
        @(posedge clk_sys);
        clear_all_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        clear_all_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        exp_in  = WORD_RESET;
        exp_dac = WORD_RESET;
        check(input_buffer, WORD_RESET);
        check(dac_buffer, WORD_RESET);
        check({13'h0, range_sel}, {13'h0, exp_rng});
        frame(CMD_COPY_DAC, 16'($random(seed)), 24);
        $display("test clear done");
        close_out();
    end
endmodule

// >>> verilog/dsr_loader.sv
// Serial command loader and range/code buffers of the DAC.
`timescale 1ns/10ps
// Functional notes
// [RL1] Host uses 32-bit frames when chaining devices.
// [RL2] 14-bit variant drops two low data bits.
// [RL3] 12-bit variant drops four low data bits.
// [RL4] Range command sets range and code together.
// [RL5] Command 1001 selects unipolar ten volt range.
// [RL6] Command 1010 selects bipolar five volt range.
// [RL7] Data-only commands keep the selected range.
// [RL8] Command, four spare bits, sixteen data bits.
// [RL9] Commands 0000/0001/0010 move data; 1111 idles.
// [RL10] Clear input zeroes every internal register. The code zeroes the buffers and chain_q only; range_sel keeps its value.
// [RL11] Power-up gives five volt unipolar, zero code.
// [RL12] Reserved commands behave like no operation.
module dsr_loader #(
    parameter int unsigned RES_BITS = 16  // Resolution: 12, 14 or 16.
) (
    input  wire logic                             clk_sys,
    input  wire logic                             arst_n,
    input  wire logic                             serial_clk,
    input  wire logic                             select_load_strobe_n,
    input  wire logic                             serial_in,
    input  wire logic                             clear_all_n,
    output logic                                  serial_out,
    output logic [RES_BITS-1:0]                   input_buffer,
    output logic [RES_BITS-1:0]                   dac_buffer,
    output logic [2:0]                            range_sel,
    output logic                                  load_done
);
    import dsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Conversion code taken from a data word.

    // Keeps the upper bits of the data word; unused low bits are dropped.
    function automatic logic [RES_BITS-1:0] code_of(
        input logic [WORD_BITS-1:0] w
    );
        code_of = w[WORD_BITS-1 -: RES_BITS];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset and pin synchronisers on the system clock.

    logic       rst_s1_q;      // First reset release stage.
    logic       rst_n;         // Released reset used by the system logic.
    logic       stb_s1_q;      // Strobe synchroniser, first stage.
    logic       stb_s2_q;      // Strobe synchroniser, second stage.
    logic       stb_s3_q;      // Delayed copy for edge detection.
    logic       clr_s1_q;      // Clear synchroniser, first stage.
    logic       clr_s2_q;      // Clear synchroniser, second stage.

    // Reset is asserted at once and released two edges later.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // The strobe idles high, so it resets high to avoid a false edge.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stb_s1_q <= 1'b1;
            stb_s2_q <= 1'b1;
            stb_s3_q <= 1'b1;
        end else begin
            stb_s1_q <= select_load_strobe_n;
            stb_s2_q <= stb_s1_q;
            stb_s3_q <= stb_s2_q;
        end
    end

    // Clear idles high; the synchronised level drives the buffers.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clr_s1_q <= 1'b1;
            clr_s2_q <= 1'b1;
        end else begin
            clr_s1_q <= clear_all_n;
            clr_s2_q <= clr_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link side: the shift chain on the serial clock.

    logic [CHAIN_BITS-1:0] chain_q;   // The input shift register.
    logic                  link_rst_n; // Reset or clear for the link side.

    // Clear reaches the chain asynchronously, since the serial clock may
    // be stopped while clear is low.
    assign link_rst_n = arst_n & clear_all_n;

    // [RL8] Shift while strobe low.
    // The strobe gates the chain directly: the serial clock only runs
    // inside a frame, so no synchroniser on this clock could ever settle.
    always_ff @(posedge serial_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            chain_q <= CHAIN_RESET;
        end else if (!select_load_strobe_n) begin
            chain_q <= {chain_q[CHAIN_BITS-2:0], serial_in};
        end
    end

    // The last chain bit feeds the next device of a daisy chain.
    assign serial_out = chain_q[CHAIN_BITS-1];

    ////////////////////////////////////////////////////////////////////////
    // Command decode on the system clock.

    logic                  load_pulse;   // Synchronised strobe rise.
    logic [3:0]            cmd_w;        // Command bits of the frame.
    logic [WORD_BITS-1:0]  word_w;       // Data word of the frame.
    logic                  is_range;     // Command is a range command.

    // The chain is read only after the strobe has risen and passed two
    // flip-flops; the serial clock is then stopped, so the word is still.
    // A host must hold the strobe high for a few system clocks.
    assign load_pulse = stb_s2_q & ~stb_s3_q;
    assign cmd_w      = chain_q[CMD_HI:CMD_LO];
    assign word_w     = chain_q[WORD_BITS-1:0];
    assign is_range   = (cmd_w >= CMD_RNG_FIRST) && (cmd_w <= CMD_RNG_LAST);

    ////////////////////////////////////////////////////////////////////////
    // Buffers, range and load marker.

    // [RL10] Clear zeroes buffers.
    // Clear is checked first: it is a level and overrides any load.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            input_buffer <= RES_BITS'(WORD_RESET);
            dac_buffer   <= RES_BITS'(WORD_RESET);
        end else if (!clr_s2_q) begin
            input_buffer <= RES_BITS'(WORD_RESET);
            dac_buffer   <= RES_BITS'(WORD_RESET);
        end else if (load_pulse) begin
            // [RL9] Data moving commands.
            // [RL2] [RL3] Truncated conversion code.
            if (cmd_w == CMD_LOAD_IN) begin
                input_buffer <= code_of(word_w);
            end else if (cmd_w == CMD_COPY_DAC) begin
                dac_buffer <= input_buffer;
            end else if (cmd_w == CMD_LOAD_BOTH || is_range) begin
                input_buffer <= code_of(word_w);
                dac_buffer   <= code_of(word_w);
            end
            // [RL12] Reserved codes idle.
            // Reserved codes and the no-operation code fall through here.
        end
    end

    // [RL4] Range updates with code.
    // Only range commands touch the range; clear leaves it alone.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // [RL11] Power-up unipolar range.
            range_sel <= RNG_RESET;
        end else if (load_pulse && clr_s2_q && is_range) begin
            // [RL5] [RL6] [RL7] Range from command.
            // Data-only commands never reach this branch, so they keep it.
            range_sel <= cmd_w[2:0];
        end
    end

    // A one-cycle marker of every executed frame, for the analog side.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            load_done <= 1'b0;
        end else begin
            load_done <= load_pulse & clr_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    logic go;  // A load that clear does not override.
    assign go = load_pulse & clr_s2_q;

    chk_clear_zeroes: assert property ( // [RL10]
        @(posedge clk_sys) disable iff (!rst_n)
        !clr_s2_q |=> (dac_buffer == '0) && (input_buffer == '0))
    else $error("Clear did not zero the buffers.");

    chk_load_both: assert property ( // [RL9] [RL2] [RL3]
        @(posedge clk_sys) disable iff (!rst_n)
        go && cmd_w == CMD_LOAD_BOTH |=>
            dac_buffer == code_of($past(word_w)) &&
            input_buffer == code_of($past(word_w)) && load_done)
    else $error("Load-both command did not fill both buffers.");

    chk_copy_dac: assert property ( // [RL9]
        @(posedge clk_sys) disable iff (!rst_n)
        go && cmd_w == CMD_COPY_DAC |=>
            dac_buffer == $past(input_buffer) && $stable(input_buffer))
    else $error("Copy command did not move the input buffer.");

    chk_load_input: assert property ( // [RL9]
        @(posedge clk_sys) disable iff (!rst_n)
        go && cmd_w == CMD_LOAD_IN |=>
            $stable(dac_buffer) && input_buffer == code_of($past(word_w)))
    else $error("Input-only load changed the DAC buffer.");

    chk_range_set: assert property ( // [RL4]
        @(posedge clk_sys) disable iff (!rst_n)
        go && is_range |=> range_sel == $past(cmd_w[2:0]) &&
            dac_buffer == code_of($past(word_w)))
    else $error("Range command did not set range and code together.");

    chk_range_keep: assert property ( // [RL7]
        @(posedge clk_sys) disable iff (!rst_n)
        load_pulse && !is_range |=> $stable(range_sel))
    else $error("Data-only command altered the range.");

    chk_reserved_idle: assert property ( // [RL12]
        @(posedge clk_sys) disable iff (!rst_n)
        go && cmd_w > CMD_LOAD_BOTH && !is_range |=>
            $stable(dac_buffer) && $stable(input_buffer) &&
            $stable(range_sel))
    else $error("Reserved command changed state.");

    chk_uni_ten: assert property ( // [RL5]
        @(posedge clk_sys) disable iff (!rst_n)
        go && cmd_w == 4'h9 |=> range_sel == RNG_U10)
    else $error("Command 1001 did not pick the ten volt range.");

    chk_bip_five: assert property ( // [RL6]
        @(posedge clk_sys) disable iff (!rst_n)
        go && cmd_w == 4'ha |=> range_sel == RNG_B5)
    else $error("Command 1010 did not pick the bipolar range.");

    chk_power_up: assert property ( // [RL11]
        @(posedge clk_sys) disable iff (!rst_n)
        !$past(rst_n) |-> range_sel == RNG_U5 && dac_buffer == '0)
    else $error("Reset state is not five volt unipolar at zero.");

endmodule
